// *** design/pced_pkg.sv ***
/*
 Package for the pin-change edge detector: register map, widths, reset
 values and bit positions.
 Assumes one 250 MHz core clock and a plain register port.
*/
`default_nettype none
package pced_pkg;
    localparam int PCED_PINS = 8;
    localparam int PCED_AW = 4;
    localparam int PCED_DW = 8;
    // Register offsets (plain port, own layout)
    localparam logic [3:0] PCED_OFF_RISE = 4'h0;
    localparam logic [3:0] PCED_OFF_FALL = 4'h1;
    localparam logic [3:0] PCED_OFF_FLAGS = 4'h2;
    localparam logic [3:0] PCED_OFF_CTRL = 4'h3;
    // Control/status register fields
    localparam int PCED_BIT_MASTER = 0;
    localparam int PCED_BIT_SUMMARY = 1;
    localparam int PCED_BIT_SLEEP = 2;
    localparam logic [7:0] PCED_RST_BYTE = 8'h00;
    localparam logic [7:0] PCED_ZERO_BYTE = 8'h00;
endpackage
`default_nettype wire

// *** design/pced_pin_change_edge_detector.sv ***
/*
 Interrupt-on-change logic for one eight-pin port, with per-pin rise and
 fall enables, sticky pin flags, a summary flag, a gated interrupt and a
 wake-up request.
 Assumes pins and register port are synchronous to ref_clk; the core
 sleep state arrives as a level from the power controller.
*/
// Behaviour
// - A wake-up is raised on a pin-change event only while the master enable is set.
// - A flag caught in sleep is set before the core runs its first instruction.
// - A rise enable bit at one arms rising-edge detection for its pin.
// - A fall enable bit at one arms falling-edge detection for its pin.
// - A pin flag sets on an enabled rising edge or an enabled falling edge.
// - Each pin flag set by an edge also sets the summary flag.
// - Pin flags are read/write, set by hardware, and cleared by writing zero.
// - With the master enable clear, flags still set but no interrupt is made.
// - The summary flag is the OR of all pin flags.
// - An edge during a clearing write leaves its flag set.
// - A pin with both enables set flags edges of either polarity.
`timescale 1ns/1ps
`default_nettype none
module pced_pin_change_edge_detector
    import pced_pkg::*;
(
    input wire logic refClk,
    input wire logic nrst,
    input wire logic [PCED_PINS-1:0] portPinN,
    input wire logic coreSleeping,
    input wire logic [PCED_AW-1:0] regAddr,
    input wire logic [PCED_DW-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [PCED_DW-1:0] regRdata,
    output logic changeIrq,
    output logic wakeRequest
);

////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [PCED_PINS-1:0] pinMeta;
        logic [PCED_PINS-1:0] pinSync;
        logic [PCED_PINS-1:0] pinPrev;
        logic primed;
        logic [PCED_DW-1:0] riseEnable;
        logic [PCED_DW-1:0] fallEnable;
        logic [PCED_DW-1:0] edgeFlags;
        logic masterEnable;
        logic [PCED_DW-1:0] rdata;
    } pced_state_s;

    pced_state_s st;
    pced_state_s next_st;
    logic [PCED_PINS-1:0] riseSeen;
    logic [PCED_PINS-1:0] fallSeen;
    logic [PCED_PINS-1:0] edgeHit;
    logic summaryFlag;
    logic rstMeta;
    logic rstSync;

    // Pins that went from low to high between two samples
    function automatic logic [PCED_PINS-1:0] risingOf(
        input logic [PCED_PINS-1:0] cur,
        input logic [PCED_PINS-1:0] prev);
        return cur & ~prev;
    endfunction

    // Pins that went from high to low between two samples
    function automatic logic [PCED_PINS-1:0] fallingOf(
        input logic [PCED_PINS-1:0] cur,
        input logic [PCED_PINS-1:0] prev);
        return ~cur & prev;
    endfunction

    function automatic logic addrHit(input logic [PCED_AW-1:0] a,
                                     input logic [PCED_AW-1:0] off);
        return a == off;
    endfunction

    // Reset synchroniser stays outside the state struct: it runs on the
    // raw pin reset while everything else uses the released copy.
    always_ff @(posedge refClk or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end
    logic rstN;
    assign rstN = rstSync;

////////////////////////////////////////////////////////////////////////////

    assign riseSeen = st.primed ? risingOf(st.pinSync, st.pinPrev) : '0;
    assign fallSeen = st.primed ? fallingOf(st.pinSync, st.pinPrev) : '0;
    assign edgeHit = (riseSeen & st.riseEnable) | (fallSeen & st.fallEnable);
    assign summaryFlag = |st.edgeFlags;

    always_comb begin
        next_st = st;
        next_st.pinMeta = portPinN;
        next_st.pinSync = st.pinMeta;
        next_st.pinPrev = st.pinSync;
        next_st.primed = 1'b1;
        next_st.rdata = PCED_ZERO_BYTE;
        if (regWrite) begin
            if (addrHit(regAddr, PCED_OFF_RISE)) begin
                next_st.riseEnable = regWdata;
            end
            if (addrHit(regAddr, PCED_OFF_FALL)) begin
                next_st.fallEnable = regWdata;
            end
            if (addrHit(regAddr, PCED_OFF_FLAGS)) begin
                next_st.edgeFlags = regWdata;
            end
            if (addrHit(regAddr, PCED_OFF_CTRL)) begin
                next_st.masterEnable = regWdata[PCED_BIT_MASTER];
            end
        end
        // hardware set wins, also in sleep
        next_st.edgeFlags = next_st.edgeFlags | edgeHit;
        if (regRead) begin
            unique case (regAddr)
                PCED_OFF_RISE: next_st.rdata = st.riseEnable;
                PCED_OFF_FALL: next_st.rdata = st.fallEnable;
                PCED_OFF_FLAGS: next_st.rdata = st.edgeFlags;
                PCED_OFF_CTRL: begin
                    next_st.rdata[PCED_BIT_MASTER] = st.masterEnable;
                    next_st.rdata[PCED_BIT_SUMMARY] = summaryFlag;
                    next_st.rdata[PCED_BIT_SLEEP] = coreSleeping;
                end
                default: next_st.rdata = PCED_ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge refClk or negedge rstN) begin
        if (!rstN) begin
            st.pinMeta <= '0;
            st.pinSync <= '0;
            st.pinPrev <= '0;
            st.primed <= 1'b0;
            st.riseEnable <= PCED_RST_BYTE;
            st.fallEnable <= PCED_RST_BYTE;
            st.edgeFlags <= PCED_RST_BYTE;
            st.masterEnable <= 1'b0;
            st.rdata <= PCED_ZERO_BYTE;
        end else begin
            st.pinMeta <= next_st.pinMeta;
            st.pinSync <= next_st.pinSync;
            st.pinPrev <= next_st.pinPrev;
            st.primed <= next_st.primed;
            st.riseEnable <= next_st.riseEnable;
            st.fallEnable <= next_st.fallEnable;
            st.edgeFlags <= next_st.edgeFlags;
            st.masterEnable <= next_st.masterEnable;
            st.rdata <= next_st.rdata;
        end
    end

////////////////////////////////////////////////////////////////////////////

    assign regRdata = st.rdata;
    assign changeIrq = st.masterEnable & summaryFlag;
    assign wakeRequest = st.masterEnable & summaryFlag & coreSleeping;

////////////////////////////////////////////////////////////////////////////

    AST_RISE_SETS_FLAG: assert property (@(posedge refClk) disable iff (!rstN)
        (riseSeen & st.riseEnable) != 0 |=>
        ((st.edgeFlags & $past(riseSeen & st.riseEnable))
         == $past(riseSeen & st.riseEnable)))
        else $error("enabled rising edge did not set its flag");
    AST_FALL_MASKED: assert property (@(posedge refClk) disable iff (!rstN)
        (regWrite && regAddr == PCED_OFF_FLAGS && fallSeen[0]
         && !st.fallEnable[0] && !(riseSeen[0] && st.riseEnable[0])) |=>
        st.edgeFlags[0] == $past(regWdata[0]))
        else $error("disabled falling edge changed a flag");
    AST_RISE_MASKED: assert property (@(posedge refClk) disable iff (!rstN)
        (regWrite && regAddr == PCED_OFF_FLAGS && riseSeen[0]
         && !st.riseEnable[0]) |=> st.edgeFlags[0] == $past(regWdata[0]))
        else $error("disabled rising edge changed a flag");
    AST_SET_WINS: assert property (@(posedge refClk) disable iff (!rstN)
        (regWrite && regAddr == PCED_OFF_FLAGS && edgeHit[7]) |=>
        st.edgeFlags[7])
        else $error("edge lost during clearing write");
    AST_WRITE_CLEARS: assert property (@(posedge refClk) disable iff (!rstN)
        (regWrite && regAddr == PCED_OFF_FLAGS && regWdata == 8'h00
         && edgeHit == 8'h00) |=> st.edgeFlags == 8'h00)
        else $error("flag write did not clear");
    AST_SUMMARY_OR: assert property (@(posedge refClk) disable iff (!rstN)
        $rose(summaryFlag) |-> $past(edgeHit) != 8'h00 || $past(regWrite))
        else $error("summary rose without cause");
    AST_IRQ_GATED: assert property (@(posedge refClk) disable iff (!rstN)
        !st.masterEnable |-> !changeIrq && !wakeRequest)
        else $error("interrupt raised with master enable clear");
    AST_WAKE_ON_EDGE: assert property (@(posedge refClk) disable iff (!rstN)
        (edgeHit != 8'h00 && st.masterEnable && coreSleeping
         && !regWrite) |=> summaryFlag && (wakeRequest || !coreSleeping))
        else $error("no wake after enabled edge in sleep");
    AST_SYNC_DELAY: assert property (@(posedge refClk) disable iff (!rstN)
        st.primed && $past(st.primed) |->
        st.pinPrev == $past(portPinN, 3))
        else $error("pin sample path latency wrong");
    AST_BOTH_EDGES: assert property (@(posedge refClk) disable iff (!rstN)
        (st.riseEnable[1] && st.fallEnable[1] && st.pinSync[1] != st.pinPrev[1]
         && st.primed) |=> st.edgeFlags[1])
        else $error("dual-enabled pin missed an edge");
    AST_FLAG_SUMMARY: assert property (@(posedge refClk) disable iff (!rstN)
        edgeHit != 8'h00 |=> summaryFlag)
        else $error("summary not set by pin flag");

////////////////////////////////////////////////////////////////////////////

    AST_RD_IDLE: assert property (
        @(posedge refClk) disable iff (!rstN)
        !regRead |=> regRdata == PCED_ZERO_BYTE)
        else $error("read data not zero outside a read");

    AST_RD_FLAGS: assert property (
        @(posedge refClk) disable iff (!rstN)
        regRead && regAddr == PCED_OFF_FLAGS |=> regRdata == $past(st.edgeFlags))
        else $error("flag read returned wrong value");

    AST_RD_RISE: assert property (
        @(posedge refClk) disable iff (!rstN)
        regRead && regAddr == PCED_OFF_RISE |=> regRdata == $past(st.riseEnable))
        else $error("rise enable read returned wrong value");

    AST_RD_FALL: assert property (
        @(posedge refClk) disable iff (!rstN)
        regRead && regAddr == PCED_OFF_FALL |=> regRdata == $past(st.fallEnable))
        else $error("fall enable read returned wrong value");

    AST_RD_SUMMARY: assert property (
        @(posedge refClk) disable iff (!rstN)
        regRead && regAddr == PCED_OFF_CTRL |=>
        regRdata[PCED_BIT_SUMMARY] == $past(summaryFlag))
        else $error("summary read returned wrong value");

    AST_FALL_SETS: assert property (
        @(posedge refClk) disable iff (!rstN)
        (fallSeen & st.fallEnable) != 0 |=> ((st.edgeFlags
        & $past(fallSeen & st.fallEnable)) == $past(fallSeen & st.fallEnable)))
        else $error("enabled falling edge did not set its flag");

    AST_FLAG_HOLDS: assert property (
        @(posedge refClk) disable iff (!rstN)
        !(regWrite && regAddr == PCED_OFF_FLAGS) && edgeHit == 8'h00 |=>
        st.edgeFlags == $past(st.edgeFlags))
        else $error("flags changed without edge or write");

    AST_SUM_FALLS: assert property (
        @(posedge refClk) disable iff (!rstN)
        $fell(summaryFlag) |->
        $past(regWrite) && $past(regAddr) == PCED_OFF_FLAGS)
        else $error("summary fell without a flag write");

    AST_IRQ_ON: assert property (
        @(posedge refClk) disable iff (!rstN)
        st.masterEnable && summaryFlag |-> changeIrq)
        else $error("enabled flag raised no interrupt");

    AST_WAKE_SLEEP: assert property (
        @(posedge refClk) disable iff (!rstN)
        wakeRequest |-> coreSleeping && changeIrq)
        else $error("wake request without sleep or interrupt");

    AST_RISE_WRITE: assert property (
        @(posedge refClk) disable iff (!rstN)
        regWrite && regAddr == PCED_OFF_RISE |=>
        st.riseEnable == $past(regWdata))
        else $error("rise enable write not taken");

    AST_MASTER_WRITE: assert property (
        @(posedge refClk) disable iff (!rstN)
        regWrite && regAddr == PCED_OFF_CTRL |=>
        st.masterEnable == $past(regWdata[PCED_BIT_MASTER]))
        else $error("master enable write not taken");

endmodule
`default_nettype wire

// *** bench/pced_pin_model.sv ***
/*
 Model of the digital sources on the eight port pins.
 Assumes the pins are synchronous to refClk and change after its edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pced_pin_model
    import pced_pkg::*;
(
    input wire logic refClk,
    output var logic [PCED_PINS-1:0] portPinN
);
    initial begin
        portPinN = 8'h00;
    end
    // Change only after an edge so the sampling flop never sees a race
    task automatic drive(input logic [PCED_PINS-1:0] v);
        @(posedge refClk);
        portPinN <= v;
    endtask
endmodule
`default_nettype wire

// *** bench/pced_pin_change_edge_detector_test.sv ***
/*
 Self-checking bench for the pin-change edge detector.
 Assumes the register port answers reads one cycle later, and pin edges
 land in the flags three edges after the pin changes.
*/
`timescale 1ns/1ps
`default_nettype none
module pced_pin_change_edge_detector_test
    import pced_pkg::*;
;
    logic refClk = 1'h0;
    logic nrst = 1'h0;
    logic coreSleeping = 1'h0;
    logic regWrite = 1'h0;
    logic regRead = 1'h0;
    logic [PCED_AW-1:0] regAddr = 4'h0;
    logic [PCED_DW-1:0] regWdata = 8'h00;
    logic [PCED_PINS-1:0] portPinN;
    logic [PCED_DW-1:0] regRdata;
    logic changeIrq;
    logic wakeRequest;
    int fails = 0;
    int numChecks = 0;

    pced_pin_change_edge_detector i_pced_pin_change_edge_detector (
        .refClk(refClk), .nrst(nrst), .portPinN(portPinN),
        .coreSleeping(coreSleeping), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .changeIrq(changeIrq),
        .wakeRequest(wakeRequest)
    );
    pced_pin_model i_pced_pin_model (.refClk(refClk), .portPinN(portPinN));

    initial begin
        forever #2 refClk = ~refClk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge refClk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge refClk);
        regWrite <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge refClk);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge refClk);
        regRead <= 1'h0;
        #1 check(regRdata, exp);
    endtask
    // Leave room for two sync stages and the flag update
    task automatic pins(input logic [7:0] v);
        i_pced_pin_model.drive(v);
        repeat (4) @(posedge refClk);
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge refClk);
        nrst <= 1'h1;
        repeat (3) @(posedge refClk);
        for (int a = 0; a < 5; a++) rd(4'(a), 8'h00);
        $display("Test reset values done");
        wr(PCED_OFF_RISE, 8'h0F);
        wr(PCED_OFF_FALL, 8'hF0);
        wr(4'hA, 8'hFF);
        rd(4'hA, 8'h00);
        rd(PCED_OFF_RISE, 8'h0F);
        rd(PCED_OFF_FALL, 8'hF0);
        pins(8'hFF);
        rd(PCED_OFF_FLAGS, 8'h0F);
        check({7'h00, changeIrq}, 8'h00);
        rd(PCED_OFF_CTRL, 8'h02);
        pins(8'h00);
        rd(PCED_OFF_FLAGS, 8'hFF);
        wr(PCED_OFF_FLAGS, 8'h00);
        rd(PCED_OFF_FLAGS, 8'h00);
        rd(PCED_OFF_CTRL, 8'h00);
        $display("Test edge enables done");
        wr(PCED_OFF_RISE, 8'h01);
        wr(PCED_OFF_FALL, 8'h01);
        wr(PCED_OFF_CTRL, 8'h01);
        coreSleeping <= 1'h1;
        pins(8'h01);
        check({6'h00, wakeRequest, changeIrq}, 8'h03);
        rd(PCED_OFF_FLAGS, 8'h01);
        rd(PCED_OFF_CTRL, 8'h07);
        wr(PCED_OFF_CTRL, 8'h00);
        #1 check({6'h00, wakeRequest, changeIrq}, 8'h00);
        wr(PCED_OFF_FLAGS, 8'h00);
        pins(8'h00);
        rd(PCED_OFF_FLAGS, 8'h01);
        $display("Test wake and both edges done");
        wr(PCED_OFF_FLAGS, 8'h00);
        i_pced_pin_model.drive(8'h01);
        @(posedge refClk);
        wr(PCED_OFF_FLAGS, 8'h00);
        rd(PCED_OFF_FLAGS, 8'h01);
        coreSleeping <= 1'h0;
        $display("Test clear during edge done");
        report_and_stop();
    end
endmodule
`default_nettype wire
